// ### design/hsm_pkg.sv
// shared constants and types for the backplane hot-swap monitor
// assumes a single 50 MHz clock and no register bus; all controls are ports
package hsm_pkg;
   // clock period in ns
   localparam int CLK_PERIOD_NS = 20;
   // half period of any flashing indicator, in ms
   localparam int FLASH_HALF_MS = 250;
   // half period in clock cycles, rounded down, never below one
   localparam int FLASH_HALF_CYCLES_RAW = (FLASH_HALF_MS * 1000000) / CLK_PERIOD_NS;
   localparam int FLASH_HALF_CYCLES = (FLASH_HALF_CYCLES_RAW < 1) ? 1 : FLASH_HALF_CYCLES_RAW;
   // default number of backplane slots watched
   localparam int NUM_SLOTS = 8;
   // diagnostic event codes
   localparam logic [15:0] CODE_BUS_FAIL = 16'h39D0;
   localparam logic [15:0] CODE_BUS_RECOVER = 16'h38D0;
   localparam logic [15:0] CODE_RECOVER_MISMATCH = 16'h38D1;
   // reset values
   localparam logic RST_SYS_FAULT = 1'h0;
   localparam logic RST_STOP = 1'h0;

   // monitor phase: waiting for the power-on scan, or supervising
   typedef enum logic {
      MD_WAIT = 1'b0,
      MD_RUN = 1'b1
   } hsm_mode_t;

   // per-slot indicator pattern
   typedef enum logic [2:0] {
      LM_OFF = 3'b000,
      LM_RUN_ON = 3'b001,
      LM_RUN_FLASH = 3'b010,
      LM_MF_ON = 3'b011,
      LM_MF_FLASH = 3'b100
   } hsm_led_t;
endpackage

// ### design/hsm_flash_gen.sv
// flash phase generator for blinking indicators
// assumes one clock; emits a square wave level, period two half counts
`timescale 1ns/1ns
module hsm_flash_gen #(
   parameter int HALF_CYCLES = 4
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   output logic o_phase
);
   localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

   logic [CW-1:0] cnt_ff; // cycles elapsed in this half period
   logic phase_ff; // current flash level

   // free-running divider; a one-cycle wrap flips the phase
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_ff <= '0;
         phase_ff <= 1'b0;
      end else if (cnt_ff == LAST) begin
         cnt_ff <= '0;
         phase_ff <= ~phase_ff;
      end else begin
         cnt_ff <= cnt_ff + CW'(1);
      end
   end

   assign o_phase = phase_ff;
endmodule

// ### design/hsm_first_set.sv
// lowest-set-bit finder for a slot change vector
// purely combinational; the caller registers whatever it acts on
`timescale 1ns/1ns
module hsm_first_set #(
   parameter int N = 8
) (
   input wire logic [N-1:0] i_vec,
   output logic o_found,
   output logic [$clog2(N)-1:0] o_idx
);
   logic [N-1:0] below; // any set bit strictly below position i
   logic [N-1:0] first; // one-hot lowest set bit

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_bit
         if (g == 0) begin : g_lo
            assign below[g] = 1'b0;
         end else begin : g_hi
            assign below[g] = below[g-1] | i_vec[g-1];
         end
         assign first[g] = i_vec[g] & ~below[g];
      end
   endgenerate

   // encode the one-hot pick; at most one bit is set
   always_comb begin
      o_idx = '0;
      for (int k = 0; k < N; k++) begin
         if (first[k]) begin
            o_idx = o_idx | ($clog2(N))'(k);
         end
      end
   end

   assign o_found = |i_vec;
endmodule

// ### design/hsm_monitor.sv
// backplane hot-swap monitor: top level
// assumes slot presence and type-match inputs synchronous to i_clock
// What this block does
// R1 - removal while running counts as module failure
// R2 - removal raises event code 39D0
// R3 - call handler if configured, else stop
// R4 - removal lights the system fault indicator
// R5 - removal invalidates all module I/O data
// R6 - identical return clears the system fault indicator
// R7 - identical return: all run on, faults off
// R8 - identical return raises event code 38D0
// R9 - identical return makes I/O data valid in every slot not holding a wrong module
// R10 - wrong module raises event code 38D1
// R11 - wrong module keeps system fault lit
// R12 - wrong module flashes its fault indicator
// R13 - wrong module invalid, all others valid unless they hold a wrong module
// R14 - power-on mismatch: fault flashes, run off
// R15 - power-on defect: earlier modules flash run
// R16 - power-on defect: later modules fault on
// R17 - fixed flash rate, steady until next event
`timescale 1ns/1ns
module hsm_monitor #(
   parameter int N_SLOTS = hsm_pkg::NUM_SLOTS,
   parameter int FLASH_HALF_CYCLES = hsm_pkg::FLASH_HALF_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [N_SLOTS-1:0] i_present,
   input wire logic [N_SLOTS-1:0] i_type_ok,
   input wire logic i_handler_cfg,
   input wire logic i_scan_done,
   input wire logic i_scan_defect,
   input wire logic [$clog2(N_SLOTS)-1:0] i_defect_slot,
   output logic o_event_valid,
   output logic [15:0] o_event_code,
   output logic o_handler_call,
   output logic o_stop,
   output logic o_system_fault_indicator,
   output logic [N_SLOTS-1:0] o_run_led,
   output logic [N_SLOTS-1:0] o_module_fault_indicator,
   output logic [N_SLOTS-1:0] o_io_valid
);
   localparam int IW = $clog2(N_SLOTS);

   hsm_pkg::hsm_mode_t mode_ff; // wait for scan, then supervise
   logic [N_SLOTS-1:0] seen_ff; // presence as last acted upon
   logic [N_SLOTS-1:0] bad_ff; // slots holding a wrong module
   logic [N_SLOTS-1:0] io_valid_ff; // per-slot I/O data validity
   logic sys_fault_ff; // system fault indicator
   logic stop_ff; // sticky stop, cleared only by reset
   logic ev_valid_ff; // one-cycle event strobe
   logic [15:0] ev_code_ff; // code of the last event
   logic call_ff; // one-cycle handler call
   hsm_pkg::hsm_led_t led_mode_ff [N_SLOTS]; // per-slot pattern
   logic [N_SLOTS-1:0] run_led_ff; // run indicators
   logic [N_SLOTS-1:0] mf_led_ff; // module fault indicators
   logic phase; // shared flash level

   logic rem_found; // some slot went absent
   logic [IW-1:0] rem_idx;
   logic ret_found; // some slot came back
   logic [IW-1:0] ret_idx;
   logic running; // supervision active
   logic do_remove; // act on a removal this cycle
   logic do_ret; // act on a return this cycle
   logic do_ident; // return of a matching module
   logic do_wrong; // return of a wrong module
   logic do_event; // any of the three events
   logic do_scan; // power-on scan accepted

   // one flash source for every blinking indicator keeps them in step
   hsm_flash_gen #(
      .HALF_CYCLES(FLASH_HALF_CYCLES)
   ) u_flash (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .o_phase(phase)
   );

   // removals outrank returns; one slot is handled per cycle, the rest wait
   hsm_first_set #(
      .N(N_SLOTS)
   ) u_rem (
      .i_vec(seen_ff & ~i_present),
      .o_found(rem_found),
      .o_idx(rem_idx)
   );

   hsm_first_set #(
      .N(N_SLOTS)
   ) u_ret (
      .i_vec(~seen_ff & i_present),
      .o_found(ret_found),
      .o_idx(ret_idx)
   );

   // event decode
   always_comb begin
      running = (mode_ff == hsm_pkg::MD_RUN);
      do_scan = (mode_ff == hsm_pkg::MD_WAIT) && i_scan_done;
      do_remove = running && rem_found; // see R1
      do_ret = running && !rem_found && ret_found;
      do_ident = do_ret && i_type_ok[ret_idx];
      do_wrong = do_ret && !i_type_ok[ret_idx];
      do_event = do_remove || do_ret;
   end

   // phase: events are ignored until the power-on scan has been taken
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_ff <= hsm_pkg::MD_WAIT;
      end else begin
         unique case (mode_ff)
            hsm_pkg::MD_WAIT: begin
               if (i_scan_done) begin
                  mode_ff <= hsm_pkg::MD_RUN;
               end
            end
            hsm_pkg::MD_RUN: begin
               mode_ff <= hsm_pkg::MD_RUN;
            end
         endcase
      end
   end

   // presence and wrong-module bookkeeping; the scan loads every slot, an event moves only the handled slot
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         seen_ff <= '0;
         bad_ff <= '0;
      end else if (do_scan) begin
         seen_ff <= i_present;
         bad_ff <= i_present & ~i_type_ok;
      end else if (do_remove) begin
         seen_ff[rem_idx] <= 1'b0;
         bad_ff[rem_idx] <= 1'b0;
      end else if (do_ret) begin
         seen_ff[ret_idx] <= 1'b1;
         bad_ff[ret_idx] <= do_wrong;
      end
   end

   // I/O data validity per slot
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         io_valid_ff <= '0;
      end else if (do_scan) begin
         io_valid_ff <= i_scan_defect ? '0 : (i_present & i_type_ok);
      end else if (do_remove) begin
         io_valid_ff <= '0; // see R5
      end else if (do_ident) begin
         io_valid_ff <= ~bad_ff; // see R9
      end else if (do_wrong) begin
         io_valid_ff <= ~(bad_ff | (N_SLOTS'(1) << ret_idx)); // see R13
      end
   end

   // system fault indicator; a wrong module never clears it
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sys_fault_ff <= hsm_pkg::RST_SYS_FAULT;
      end else if (do_remove || do_wrong) begin
         sys_fault_ff <= 1'b1; // see R4, see R11
      end else if (do_ident) begin
         sys_fault_ff <= 1'b0; // see R6
      end
   end

   // diagnostic event strobe and code
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ev_valid_ff <= 1'b0;
         ev_code_ff <= 16'h0000;
      end else begin
         ev_valid_ff <= do_event;
         if (do_remove) begin
            ev_code_ff <= hsm_pkg::CODE_BUS_FAIL; // see R2
         end else if (do_ident) begin
            ev_code_ff <= hsm_pkg::CODE_BUS_RECOVER; // see R8
         end else if (do_wrong) begin
            ev_code_ff <= hsm_pkg::CODE_RECOVER_MISMATCH; // see R10
         end
      end
   end

   // handler call or stop; stop is sticky because only a restart leaves it
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         call_ff <= 1'b0;
         stop_ff <= hsm_pkg::RST_STOP;
      end else begin
         call_ff <= do_event && i_handler_cfg; // see R3
         if (do_event && !i_handler_cfg) begin
            stop_ff <= 1'b1; // see R3
         end
      end
   end

   // per-slot indicator pattern and drive
   genvar s;
   generate
      for (s = 0; s < N_SLOTS; s++) begin : g_slot
         // pattern changes only on scan or event, so steady states hold
         always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
               led_mode_ff[s] <= hsm_pkg::LM_OFF;
            end else if (do_scan) begin
               if (!i_present[s]) begin
                  led_mode_ff[s] <= hsm_pkg::LM_OFF;
               end else if (i_scan_defect) begin
                  if (IW'(s) < i_defect_slot) begin
                     led_mode_ff[s] <= hsm_pkg::LM_RUN_FLASH; // see R15
                  end else begin
                     led_mode_ff[s] <= hsm_pkg::LM_MF_ON; // see R16
                  end
               end else if (!i_type_ok[s]) begin
                  led_mode_ff[s] <= hsm_pkg::LM_MF_FLASH; // see R14
               end else begin
                  led_mode_ff[s] <= hsm_pkg::LM_RUN_ON;
               end
            end else if (do_ident) begin
               led_mode_ff[s] <= hsm_pkg::LM_RUN_ON; // see R7
            end else if (do_wrong && ret_idx == IW'(s)) begin
               led_mode_ff[s] <= hsm_pkg::LM_MF_FLASH; // see R12
            end
         end

         // flashing follows the shared divider phase
         always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
               run_led_ff[s] <= 1'b0;
               mf_led_ff[s] <= 1'b0;
            end else begin
               run_led_ff[s] <= (led_mode_ff[s] == hsm_pkg::LM_RUN_ON) ||
                  ((led_mode_ff[s] == hsm_pkg::LM_RUN_FLASH) && phase); // see R17
               mf_led_ff[s] <= (led_mode_ff[s] == hsm_pkg::LM_MF_ON) ||
                  ((led_mode_ff[s] == hsm_pkg::LM_MF_FLASH) && phase); // see R17
            end
         end
      end
   endgenerate

   assign o_event_valid = ev_valid_ff;
   assign o_event_code = ev_code_ff;
   assign o_handler_call = call_ff;
   assign o_stop = stop_ff;
   assign o_system_fault_indicator = sys_fault_ff;
   assign o_run_led = run_led_ff;
   assign o_module_fault_indicator = mf_led_ff;
   assign o_io_valid = io_valid_ff;

   // checks; all of them are skipped while reset is low
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   // an event shows its strobe and its code in the same cycle
   sequence s_event_out(logic [15:0] code);
      o_event_valid && (o_event_code == code);
   endsequence

   // removal: strobe, code, fault lamp and I/O validity one cycle later
   a_remove_code: assert property (do_remove |=> s_event_out(hsm_pkg::CODE_BUS_FAIL)) // see R2
      else $error("removal did not raise the bus failure code");
   a_remove_fault: assert property (do_remove |=> o_system_fault_indicator) // see R4
      else $error("removal left the system fault indicator off");
   a_remove_io: assert property (do_remove |=> (o_io_valid == '0)) // see R5
      else $error("removal left some I/O data valid");
   // handler or stop follows the configuration seen when the event is taken
   a_stop_no_handler: assert property ( // see R3
      do_event && !i_handler_cfg |=> o_stop && !o_handler_call)
      else $error("missing handler did not stop");
   a_handler_runs: assert property ( // see R3
      do_event && i_handler_cfg && !o_stop |=> o_handler_call && !o_stop)
      else $error("configured handler not called or stopped");
   // the fault lamp settles one cycle before the slot indicators do
   a_ident_leds: assert property ( // see R7
      do_ident |=> !o_system_fault_indicator ##1
         ((&o_run_led) && (o_module_fault_indicator == '0)))
      else $error("identical return did not restore indicators");
   a_ident_code: assert property ( // see R9
      do_ident |=> s_event_out(hsm_pkg::CODE_BUS_RECOVER) ##0 (o_io_valid == ~bad_ff))
      else $error("identical return code or I/O validity wrong");
   a_wrong_slot: assert property ( // see R13
      do_wrong |=> s_event_out(hsm_pkg::CODE_RECOVER_MISMATCH) ##0
         (o_system_fault_indicator && !o_io_valid[$past(ret_idx)]))
      else $error("wrong module event handled incorrectly");
   // a flashing indicator shows the phase seen one edge earlier
   a_wrong_flash: assert property ( // see R12
      do_wrong |=> ##1 (o_module_fault_indicator[$past(ret_idx, 2)] == $past(phase)))
      else $error("wrong module fault indicator not flashing");
   a_scan_mismatch: assert property ( // see R14
      do_scan && !i_scan_defect && i_present[0] && !i_type_ok[0] |=> ##1
         !o_run_led[0] && (o_module_fault_indicator[0] == $past(phase)))
      else $error("power-on mismatch slot not flashing its fault indicator");
   // slot 0 stands before any defect other than its own
   a_defect_run: assert property ( // see R15
      do_scan && i_scan_defect && i_present[0] && (i_defect_slot != '0) |=> ##1
         (o_run_led[0] == $past(phase)) && !o_module_fault_indicator[0])
      else $error("slot before the defect not flashing its run indicator");
   // the last slot can never stand before the defect
   a_defect_fault: assert property ( // see R16
      do_scan && i_scan_defect && i_present[N_SLOTS-1] |=> ##1
         o_module_fault_indicator[N_SLOTS-1] && !o_run_led[N_SLOTS-1])
      else $error("slot after the defect not showing a steady fault");
endmodule

// ### sim/hsm_slot_model.sv
// behavioural model of the backplane modules seen by the hot-swap monitor
// assumes the bench calls its tasks; changes land just after a falling edge
`timescale 1ns/1ns
module hsm_slot_model #(
   parameter int N = 8
) (
   input wire logic i_clock,
   output logic [N-1:0] o_present,
   output logic [N-1:0] o_type_ok
);
   // every slot starts filled with the configured module type
   initial begin
      o_present = '1;
      o_type_ok = '1;
   end

   // fill the whole rack at once, some slots possibly of the wrong type
   task automatic fill(input logic [N-1:0] ok);
      @(negedge i_clock);
      o_present = '1;
      o_type_ok = ok;
   endtask

   // pull or plug one module; an empty slot never claims a type match
   task automatic set_slot(input int k, input logic p, input logic ok);
      @(negedge i_clock);
      o_present[k] = p;
      o_type_ok[k] = p & ok;
   endtask
endmodule

// ### sim/testbench.sv
// bench for the backplane hot-swap monitor: power-on patterns and hot-swap events
// assumes hsm_slot_model as the rack and a shortened flash period
`timescale 1ns/1ns
module testbench;
   localparam int N = 8; // slots under test
   localparam int HALF = 4; // short flash half period keeps the run brief
   logic i_clock; // bench clock
   logic i_rst_b; // active low reset
   logic [N-1:0] present; // occupancy from the rack model
   logic [N-1:0] type_ok; // type match from the rack model
   logic i_handler_cfg; // handler routine configured
   logic i_scan_done; // power-on scan strobe
   logic i_scan_defect; // scan found a defect
   logic [2:0] i_defect_slot; // defective slot index
   logic o_event_valid;
   logic [15:0] o_event_code;
   logic o_handler_call;
   logic o_stop;
   logic o_system_fault_indicator;
   logic [N-1:0] o_run_led;
   logic [N-1:0] o_module_fault_indicator;
   logic [N-1:0] o_io_valid;
   int num_errors; // mismatches seen
   int checked; // comparisons made

   hsm_slot_model #(.N(N)) hsm_slot_model_i (.i_clock(i_clock), .o_present(present),
      .o_type_ok(type_ok));
   hsm_monitor #(.N_SLOTS(N), .FLASH_HALF_CYCLES(HALF)) hsm_monitor_i (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_present(present), .i_type_ok(type_ok),
      .i_handler_cfg(i_handler_cfg), .i_scan_done(i_scan_done),
      .i_scan_defect(i_scan_defect), .i_defect_slot(i_defect_slot),
      .o_event_valid(o_event_valid), .o_event_code(o_event_code),
      .o_handler_call(o_handler_call), .o_stop(o_stop),
      .o_system_fault_indicator(o_system_fault_indicator), .o_run_led(o_run_led),
      .o_module_fault_indicator(o_module_fault_indicator), .o_io_valid(o_io_valid));

   // 50 MHz clock
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   // one comparison, four-state exact
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // fill the rack, reset, then hand over one scan result
   task automatic scan(input logic [N-1:0] ok, input logic dfct, input logic [2:0] slot);
      hsm_slot_model_i.fill(ok);
      i_rst_b = 1'b0;
      i_handler_cfg = 1'b1;
      repeat (5) @(negedge i_clock);
      i_rst_b = 1'b1;
      @(negedge i_clock);
      i_scan_done = 1'b1;
      i_scan_defect = dfct;
      i_defect_slot = slot;
      @(negedge i_clock);
      i_scan_done = 1'b0;
      i_scan_defect = 1'b0;
      repeat (3) @(negedge i_clock);
   endtask

   // wait a bounded time for one event, check its outputs and its one-cycle pulse
   task automatic ev(input logic [15:0] code, input logic call, input logic stp,
      input logic sf, input logic [N-1:0] io);
      int n;
      n = 0;
      while (o_event_valid !== 1'b1 && n < 6) begin
         @(negedge i_clock);
         n++;
      end
      chk({15'h0, o_event_valid}, 16'h1, "event pulse");
      chk(o_event_code, code, "event code");
      chk({14'h0, o_handler_call, o_stop}, {14'h0, call, stp}, "handler or stop");
      chk({15'h0, o_system_fault_indicator}, {15'h0, sf}, "system fault");
      chk({8'h0, o_io_valid}, {8'h0, io}, "io valid");
      @(negedge i_clock);
      chk({14'h0, o_event_valid, o_handler_call}, 16'h0, "pulse length");
   endtask

   // masked slots must show both levels over two flash periods
   task automatic flash(input logic [N-1:0] m, input logic mf, input string what);
      logic [N-1:0] hi;
      logic [N-1:0] lo;
      logic [N-1:0] v;
      hi = '0;
      lo = '0;
      repeat (4 * HALF) begin
         @(negedge i_clock);
         v = mf ? o_module_fault_indicator : o_run_led;
         hi |= v & m;
         lo |= ~v & m;
      end
      chk({8'h0, hi & lo}, {8'h0, m}, what);
   endtask

   // final counts and verdict
   task automatic give_verdict;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs about a hundred cycles
   initial begin
      #(20 * 3000);
      num_errors++;
      $display("ERROR at %0t: watchdog expired", $time);
      give_verdict();
   end

   // main sequence
   initial begin
      i_rst_b = 1'b0;
      i_handler_cfg = 1'b1;
      i_scan_done = 1'b0;
      i_scan_defect = 1'b0;
      i_defect_slot = 3'h0;
      num_errors = 0;
      checked = 0;
      // power-on with wrong modules in slots 0 and 2
      scan(8'hFA, 1'b0, 3'h0);
      chk({8'h0, o_run_led}, 16'h00FA, "run with mismatch");
      flash(8'h05, 1'b1, "mismatch fault flash");
      chk({8'h0, o_module_fault_indicator & 8'hFA}, 16'h0, "fault elsewhere");
      $display("test power-on mismatch done");
      // power-on with a defective module in slot 5
      scan(8'hFF, 1'b1, 3'h5);
      flash(8'h1F, 1'b0, "run flash before defect");
      chk({8'h0, o_module_fault_indicator}, 16'h00E0, "fault from defect on");
      chk({8'h0, o_run_led & 8'hE0}, 16'h0, "run from defect off");
      $display("test power-on defect done");
      // clean power-on, then removal and identical return of slot 3
      scan(8'hFF, 1'b0, 3'h0);
      chk({8'h0, o_run_led}, 16'h00FF, "all run on");
      hsm_slot_model_i.set_slot(3, 1'b0, 1'b0);
      ev(16'h39D0, 1'b1, 1'b0, 1'b1, 8'h00);
      hsm_slot_model_i.set_slot(3, 1'b1, 1'b1);
      ev(16'h38D0, 1'b1, 1'b0, 1'b0, 8'hFF);
      chk({o_run_led, o_module_fault_indicator}, 16'hFF00, "leds after return");
      $display("test identical return done");
      // slot 6 pulled and a wrong module plugged back
      hsm_slot_model_i.set_slot(6, 1'b0, 1'b0);
      ev(16'h39D0, 1'b1, 1'b0, 1'b1, 8'h00);
      hsm_slot_model_i.set_slot(6, 1'b1, 1'b0);
      ev(16'h38D1, 1'b1, 1'b0, 1'b1, 8'hBF);
      flash(8'h40, 1'b1, "wrong module flash");
      chk({15'h0, o_system_fault_indicator}, 16'h1, "fault stays lit");
      $display("test wrong module done");
      // no handler configured: removal stops the controller
      i_handler_cfg = 1'b0;
      hsm_slot_model_i.set_slot(0, 1'b0, 1'b0);
      ev(16'h39D0, 1'b0, 1'b1, 1'b1, 8'h00);
      repeat (3) @(negedge i_clock);
      chk({15'h0, o_stop}, 16'h1, "stop held");
      $display("test stop without handler done");
      give_verdict();
   end
endmodule
